/* tb/bicr_ctrl_regs_bench.sv */
/*
  Self-checking bench for the control register slice.
  Assumes the far-end model drives txn_active and a watchdog step of 4 cycles.
*/
`default_nettype none
module bicr_ctrl_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } bicr_row_t;
  logic core_clk, rst_n, pclk_present, fwd_osc_ctrl, self_test_req, io_level_strap_pin;
  logic io_level_select, osc_run, txn_active, wd_abort, fwd_go, fwd_drop;
  logic scl_raw, sda_raw, scl_clean, sda_clean, start;
  logic [7:0]              reg_rdata, len, d;
  logic [6:0]              own_id, remote_deser_id, remote_target_id;
  bicr_pkg::bicr_reg_req_t reg_req;
  bicr_pkg::bicr_target_t  target;
  bicr_pkg::bicr_osc_t     oscillator_source_select;
  int                      mismatches, comparisons, n, go, drop, hits;
  bicr_row_t rows [12] = '{
    '{1'b0, 8'h14, 8'h00, 8'h00}, '{1'b0, 8'h15, 8'h00, 8'h01}, '{1'b0, 8'h16, 8'h00, 8'hfe},
    '{1'b0, 8'h17, 8'h00, 8'h1e}, '{1'b1, 8'h21, 8'h5a, 8'h00}, '{1'b1, 8'h15, 8'hb6, 8'h00},
    '{1'b1, 8'h15, 8'h01, 8'h00}, '{1'b1, 8'h15, 8'hb5, 8'h01}, '{1'b1, 8'h15, 8'hb7, 8'h01},
    '{1'b1, 8'h14, 8'hff, 8'h06}, '{1'b1, 8'h16, 8'h0b, 8'h0b}, '{1'b1, 8'h17, 8'ha5, 8'ha5}};

  bicr_ctrl_regs #(.WD_UNIT_CYCLES(4)) i_dut (.core_clk, .rst_n, .reg_req, .reg_rdata, .pclk_present,
    .fwd_osc_ctrl, .self_test_req, .io_level_strap_pin, .io_level_select, .oscillator_source_select,
    .osc_run, .txn_active, .wd_abort, .target, .own_id, .remote_deser_id, .remote_target_id,
    .fwd_go, .fwd_drop, .scl_raw, .sda_raw, .scl_clean, .sda_clean);
  bicr_far_model i_far (.core_clk, .rst_n, .start, .len, .wd_abort, .txn_active);

  always #2 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    @(posedge core_clk);
    #1;
    v = reg_rdata;
  endtask : reg_rd

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
  endtask : do_reset

  // Bounded wait: 0 scl_clean low, 1 sda_clean low, 2 wd_abort high
  task automatic wait_sig(input int sel, input int lim, output int cnt);
    logic v;
    cnt = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      cnt++;
      v = (sel == 0) ? scl_clean === 1'b0 : (sel == 1) ? sda_clean === 1'b0 : wd_abort === 1'b1;
    end
    while (!v && cnt < lim);
    if (!v)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      final_report();
    end
  endtask : wait_sig

  task automatic start_txn(input logic [7:0] l);
    @(posedge core_clk);
    start <= 1'b1;
    len   <= l;
    @(posedge core_clk);
    start <= 1'b0;
  endtask : start_txn

  task automatic count_aborts(input int cyc, output int h);
    h = 0;
    repeat (cyc)
    begin
      @(posedge core_clk);
      #1;
      if (wd_abort !== 1'b0)
        h++;
    end
  endtask : count_aborts

  task automatic send_target(input logic [6:0] id, output int g, output int dr);
    g = 0;
    dr = 0;
    @(posedge core_clk);
    target <= '{valid: 1'b1, id: id};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      if (i == 0)
        target.valid <= 1'b0;
      #1;
      if (fwd_go === 1'b1)
        g++;
      if (fwd_drop === 1'b1)
        dr++;
    end
  endtask : send_target

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 0; rst_n = 0; pclk_present = 0; fwd_osc_ctrl = 1; self_test_req = 0;
    io_level_strap_pin = 0; scl_raw = 1; sda_raw = 1; start = 0; len = 0;
    own_id = 7'h0c; remote_deser_id = 7'h2c; remote_target_id = 7'h50;
    reg_req = '0; target = '0; mismatches = 0; comparisons = 0;
    do_reset();
    chk({7'h0, io_level_select}, 8'h01, "strap low level");
    foreach (rows[i])
    begin
      if (rows[i].wr)
        reg_wr(rows[i].addr, rows[i].wdata);
      reg_rd(rows[i].addr, d);
      chk(d, rows[i].exp, "register row");
    end
    reg_wr(8'h15, 8'hb6);
    @(posedge core_clk);
    #1;
    chk({7'h0, io_level_select}, 8'h00, "key clear level");
    $display("test registers done");
    // Oscillator source in functional and self-test mode
    for (int st = 0; st < 2; st++)
    begin
      self_test_req <= st[0];
      for (int c = 0; c < 4; c++)
      begin
        reg_wr(8'h14, {5'h0, c[1:0], 1'b0});
        repeat (8) @(posedge core_clk);
        #1;
        chk(8'(oscillator_source_select), (st == 0 && c == 0) ? 8'h01 : 8'(c), "osc select");
        chk({7'h0, osc_run}, (st == 0 || c != 0) ? 8'h01 : 8'h00, "osc run");
        reg_rd(8'h14, d);
        chk(d, {5'h0, c[1:0], st[0]}, "self-test bit");
      end
    end
    self_test_req <= 1'b0;
    pclk_present  <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk({7'h0, osc_run}, 8'h00, "pixel clock present");
    pclk_present <= 1'b0;
    fwd_osc_ctrl <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk({7'h0, osc_run}, 8'h00, "oscillator control bit clear");
    fwd_osc_ctrl <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk({7'h0, osc_run}, 8'h01, "oscillator control bit set");
    $display("test oscillator done");
    // Watchdog: timeout of 2 steps, then short and disabled cases
    reg_wr(8'h16, 8'h04);
    start_txn(8'd200);
    wait_sig(2, 60, n);
    chk(8'(n), 8'd9, "watchdog timeout");
    @(posedge core_clk);
    #1;
    chk({7'h0, wd_abort}, 8'h00, "abort width");
    repeat (4) @(posedge core_clk);
    start_txn(8'd3);
    count_aborts(30, hits);
    chk(8'(hits), 8'h00, "short transaction");
    reg_wr(8'h16, 8'h05);
    start_txn(8'd30);
    count_aborts(40, hits);
    chk(8'(hits), 8'h00, "watchdog disabled");
    $display("test watchdog done");
    // Forwarding decisions for own, remote and foreign IDs
    for (int pa = 0; pa < 2; pa++)
    begin
      reg_wr(8'h17, {pa[0], 7'h00});
      for (int k = 0; k < 4; k++)
      begin
        send_target(k == 0 ? own_id : k == 1 ? remote_deser_id : k == 2 ? remote_target_id : 7'h33, go, drop);
        chk(8'(go), (k == 1 || k == 2 || (pa == 1 && k == 3)) ? 8'h01 : 8'h00, "forward");
        chk(8'(go + drop), 8'h01, "one outcome");
      end
    end
    $display("test forwarding done");
    // Glitch filter at full depth, then SDA hold at 0 and 7
    reg_wr(8'h17, 8'h0f);
    scl_raw <= 1'b0;
    repeat (8) @(posedge core_clk);
    scl_raw <= 1'b1;
    hits = 0;
    repeat (40)
    begin
      @(posedge core_clk);
      #1;
      if (scl_clean !== 1'b1)
        hits++;
    end
    chk(8'(hits), 8'h00, "glitch rejected");
    scl_raw <= 1'b0;
    wait_sig(0, 60, n);
    chk(8'(n >= 20 && n <= 30), 8'h01, "long pulse passes");
    scl_raw <= 1'b1;
    for (int h = 0; h < 8; h += 7)
    begin
      reg_wr(8'h17, {1'b0, h[2:0], 4'h0});
      repeat (100) @(posedge core_clk);
      sda_raw <= 1'b0;
      wait_sig(1, 120, n);
      chk(8'(n >= h * 10 + 2 && n <= h * 10 + 12), 8'h01, "sda hold");
      sda_raw <= 1'b1;
    end
    $display("test pins done");
    // Strap high selects 1.8V after a second reset
    io_level_strap_pin <= 1'b1;
    do_reset();
    chk({7'h0, io_level_select}, 8'h00, "strap high level");
    reg_rd(8'h15, d);
    chk(d, 8'h00, "strap high read");
    $display("test strap done");
    final_report();
  end
endmodule : bicr_ctrl_regs_bench
`default_nettype wire

/* tb/bicr_far_model.sv */
/*
  Far-end model: holds one control channel transaction open for a set number of cycles.
  Assumes start is a one-cycle request from the bench, driven on core_clk.
*/
`default_nettype none
module bicr_far_model (
  input  wire logic       core_clk,  // Core clock
  input  wire logic       rst_n,     // Synchronous reset
  input  wire logic       start,     // Begin a transaction
  input  wire logic [7:0] len,       // Cycles until it completes
  input  wire logic       wd_abort,  // Abort from the watchdog
  output logic            txn_active // Transaction in flight
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] left_q;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      txn_active <= 1'b0;
      left_q     <= 8'h00;
    end
    else if (txn_active)
    begin
      // Gives up at once when aborted, so the watchdog can rearm
      if (wd_abort || left_q == 8'h00)
        txn_active <= 1'b0;
      left_q <= left_q - 8'h01;
    end
    else if (start)
    begin
      txn_active <= 1'b1;
      left_q     <= len;
    end
  end
endmodule : bicr_far_model
`default_nettype wire

/* verilog/bicr_ctrl_regs.sv */
/*
  Register slice: self-test clock source, bus level select, control channel watchdog, local bus control.
  Assumes the serial control bus engine delivers decoded byte accesses on the same clock, and that
  transaction activity and target IDs come from logic on core_clk.
*/
//
// Behaviour
// - Functional oscillator frequency follows the two-bit source field when pixel clock absent.
// - In self-test the same field picks pixel clock, 50, 100 or 25 MHz.
// - Bit 0 of self-test register reads self-test state, default disabled.
// - Level select loads from strap after reset: low gives 3.3V, high 1.8V.
// - Level register reads 1 for 3.3V signalling, 0 for 1.8V.
// - Only write 0xb5 sets level select, only 0xb6 clears it.
// - Enabled watchdog aborts a channel transaction exceeding the programmed timeout.
// - Timeout is bits 7:1 in 2 ms steps, reset value from 0xfe.
// - Watchdog bit 0: 0 runs the timer, 1 disables it.
// - Pass-all clear forwards only remote deserializer or remote target IDs.
// - Pass-all set forwards every ID except the serializer's own.
// - SDA input held relative to SCL by bits 6:4 in 40 ns steps.
// - Glitches on SCL and SDA up to filter depth, 5 ns steps, rejected.
`default_nettype none
module bicr_ctrl_regs #(
  parameter int WD_UNIT_CYCLES = bicr_pkg::WD_UNIT_CYC // Cycles per watchdog step
) (
  input  wire logic                    core_clk,      // 250 MHz core clock
  input  wire logic                    rst_n,         // Synchronous reset
  input  wire bicr_pkg::bicr_reg_req_t reg_req,       // Decoded register access
  output logic [7:0]                   reg_rdata,     // Read data, one cycle after rd
  input  wire logic                    pclk_present,  // Pixel clock detected
  input  wire logic                    fwd_osc_ctrl,  // Oscillator-in-functional-mode control bit
  input  wire logic                    self_test_req, // Self-test enable pin
  input  wire logic                    io_level_strap_pin, // Level strap pin
  output logic                         io_level_select,    // 1: 3.3V, 0: 1.8V
  output bicr_pkg::bicr_osc_t          oscillator_source_select, // Frame clock choice
  output logic                         osc_run,       // Oscillator clock in use
  input  wire logic                    txn_active,    // Channel transaction in flight
  output logic                         wd_abort,      // One-cycle abort pulse
  input  wire bicr_pkg::bicr_target_t  target,        // Target ID of local access
  input  wire logic [6:0]              own_id,        // Serializer target ID
  input  wire logic [6:0]              remote_deser_id, // Remote deserializer ID
  input  wire logic [6:0]              remote_target_id, // Remote target ID
  output logic                         fwd_go,        // Forward access, pulse
  output logic                         fwd_drop,      // Keep access local, pulse
  input  wire logic                    scl_raw,       // SCL pin
  input  wire logic                    sda_raw,       // SDA pin
  output logic                         scl_clean,     // Filtered SCL
  output logic                         sda_clean      // Filtered, held SDA
);
  typedef struct packed {
    logic [1:0]                   osc_fld;
    logic                         st_en;
    logic                         level;
    logic [7:0]                   wd_reg;
    logic [7:0]                   lbc_reg;
    logic [7:0]                   rdata;
    logic [2:0]                   strap_s;
    logic [2:0]                   st_s;
    logic [2:0]                   strap_age;
    logic                         strap_done;
    bicr_pkg::bicr_wd_state_t     wd_st;
    logic [31:0]                  pre;
    logic [6:0]                   units;
    logic                         abort;
    logic                         go;
    logic                         drop;
    bicr_pkg::bicr_osc_t          osc;
    logic                         osc_on;
    logic [bicr_pkg::HOLD_MAX_CYC-1:0] sda_line;
    logic                         scl_o;
    logic                         sda_o;
  } bicr_state_t;

  bicr_state_t s_q;
  bicr_state_t s_d;
  logic        scl_f;
  logic        sda_f;
  logic [6:0]  wd_timeout;
  logic [2:0]  hold_fld;

  assign wd_timeout = s_q.wd_reg[bicr_pkg::WD_TO_LSB +: 7];
  assign hold_fld   = s_q.lbc_reg[bicr_pkg::HOLD_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////////
  bicr_glitch_filter u_scl_filt (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .line_raw (scl_raw),
    .depth    (s_q.lbc_reg[bicr_pkg::FILT_LSB +: 4]),
    .line_out (scl_f)
  );

  bicr_glitch_filter u_sda_filt (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .line_raw (sda_raw),
    .depth    (s_q.lbc_reg[bicr_pkg::FILT_LSB +: 4]),
    .line_out (sda_f)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d         = s_q;
    s_d.abort   = 1'b0;
    s_d.go      = 1'b0;
    s_d.drop    = 1'b0;
    s_d.strap_s = {s_q.strap_s[1:0], io_level_strap_pin};
    s_d.st_s    = {s_q.st_s[1:0], self_test_req};
    s_d.strap_age = {s_q.strap_age[1:0], 1'b1};

    // Self-test follows the pin once the last two stages agree
    if (s_q.st_s[1] == s_q.st_s[2])
      s_d.st_en = s_q.st_s[2];

    // Strap is caught once, only after the synchroniser has flushed its reset zeros
    if (!s_q.strap_done && s_q.strap_age[2] && (s_q.strap_s[1] == s_q.strap_s[2]))
    begin
      s_d.level      = ~s_q.strap_s[2];
      s_d.strap_done = 1'b1;
    end

    // Register writes
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        bicr_pkg::SELF_TEST_OFF: s_d.osc_fld = reg_req.wdata[bicr_pkg::OSC_LSB +: 2];
        bicr_pkg::LEVEL_OFF:
        begin
          if (reg_req.wdata == bicr_pkg::LEVEL_SET_KEY)
            s_d.level = 1'b1;
          else if (reg_req.wdata == bicr_pkg::LEVEL_CLR_KEY)
            s_d.level = 1'b0;
        end
        bicr_pkg::WATCHDOG_OFF:  s_d.wd_reg  = reg_req.wdata;
        bicr_pkg::LOCAL_BUS_OFF: s_d.lbc_reg = reg_req.wdata;
        default: ;
      endcase
    end

    // Register reads; unmapped offsets read zero
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        bicr_pkg::SELF_TEST_OFF: s_d.rdata = {5'h00, s_q.osc_fld, s_q.st_en};
        bicr_pkg::LEVEL_OFF:     s_d.rdata = {7'h00, s_q.level};
        bicr_pkg::WATCHDOG_OFF:  s_d.rdata = s_q.wd_reg;
        bicr_pkg::LOCAL_BUS_OFF: s_d.rdata = s_q.lbc_reg;
        default:                 s_d.rdata = 8'h00;
      endcase
    end

    // Clock source; code 00 outside self-test still means 50 MHz
    s_d.osc_on = s_q.st_en ? (s_q.osc_fld != 2'h0) : (!pclk_present && fwd_osc_ctrl);
    if (s_q.st_en)
      s_d.osc = bicr_pkg::bicr_osc_t'(s_q.osc_fld);
    else if (s_q.osc_fld == 2'h0)
      s_d.osc = bicr_pkg::OSC_50;
    else
      s_d.osc = bicr_pkg::bicr_osc_t'(s_q.osc_fld);

    // Watchdog; a zero timeout aborts after the first step
    unique case (s_q.wd_st)
      bicr_pkg::WD_IDLE:
      begin
        s_d.pre   = 32'h0;
        s_d.units = 7'h00;
        if (txn_active && !s_q.wd_reg[bicr_pkg::WD_DIS_BIT])
          s_d.wd_st = bicr_pkg::WD_RUN;
      end
      bicr_pkg::WD_RUN:
      begin
        if (!txn_active || s_q.wd_reg[bicr_pkg::WD_DIS_BIT])
          s_d.wd_st = bicr_pkg::WD_IDLE;
        else if (s_q.pre == 32'(WD_UNIT_CYCLES - 1))
        begin
          s_d.pre   = 32'h0;
          s_d.units = s_q.units + 7'h01;
          if ((s_q.units + 7'h01) >= wd_timeout)
          begin
            s_d.abort = 1'b1;
            s_d.wd_st = bicr_pkg::WD_ABORT;
          end
        end
        else
          s_d.pre = s_q.pre + 32'h1;
      end
      bicr_pkg::WD_ABORT:
      begin
        if (!txn_active)
          s_d.wd_st = bicr_pkg::WD_IDLE;
      end
      default: s_d.wd_st = bicr_pkg::WD_IDLE;
    endcase

    // Forwarding decision
    if (target.valid)
    begin
      if (target.id == own_id)
        s_d.drop = 1'b1;
      else if (s_q.lbc_reg[bicr_pkg::PASS_ALL_BIT])
        s_d.go = 1'b1;
      else if ((target.id == remote_deser_id) || (target.id == remote_target_id))
        s_d.go = 1'b1;
      else
        s_d.drop = 1'b1;
    end

    // SDA hold line, a tap per 40 ns step
    s_d.sda_line = {s_q.sda_line[bicr_pkg::HOLD_MAX_CYC-2:0], sda_f};
    s_d.scl_o    = scl_f;
    if (hold_fld == 3'h0)
      s_d.sda_o = sda_f;
    else
      s_d.sda_o = s_q.sda_line[int'(hold_fld) * bicr_pkg::HOLD_STEP_CYC - 1];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_q            <= '0;
      s_q.osc_fld    <= bicr_pkg::SELF_TEST_RST[bicr_pkg::OSC_LSB +: 2];
      s_q.st_en      <= bicr_pkg::SELF_TEST_RST[bicr_pkg::ST_EN_BIT];
      s_q.level      <= bicr_pkg::LEVEL_RST[0];
      s_q.wd_reg     <= bicr_pkg::WATCHDOG_RST;
      s_q.lbc_reg    <= bicr_pkg::LOCAL_BUS_RST;
      s_q.osc        <= bicr_pkg::OSC_50;
      s_q.sda_line   <= '1;
      s_q.scl_o      <= 1'b1;
      s_q.sda_o      <= 1'b1;
      s_q.wd_st      <= bicr_pkg::WD_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata                = s_q.rdata;
  assign io_level_select          = s_q.level;
  assign oscillator_source_select = s_q.osc;
  assign osc_run                  = s_q.osc_on;
  assign wd_abort                 = s_q.abort;
  assign fwd_go                   = s_q.go;
  assign fwd_drop                 = s_q.drop;
  assign scl_clean                = s_q.scl_o;
  assign sda_clean                = s_q.sda_o;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_key_write(logic [7:0] key);
    reg_req.wr && reg_req.addr == bicr_pkg::LEVEL_OFF && reg_req.wdata == key;
  endsequence

  a_level_set_key: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_key_write(bicr_pkg::LEVEL_SET_KEY) |=> io_level_select)
    else $error("set key did not select 3.3V");
  a_level_clr_key: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_key_write(bicr_pkg::LEVEL_CLR_KEY) |=> !io_level_select)
    else $error("clear key did not select 1.8V");
  a_level_only_keys: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_q.strap_done && $past(s_q.strap_done) && $changed(io_level_select)
      |-> $past(reg_req.wr) && $past(reg_req.addr) == bicr_pkg::LEVEL_OFF)
    else $error("level changed without a keyed write");
  a_level_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == bicr_pkg::LEVEL_OFF |=> reg_rdata == {7'h00, $past(s_q.level)})
    else $error("level read does not match state");
  a_self_test_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == bicr_pkg::SELF_TEST_OFF |=> reg_rdata[0] == $past(s_q.st_en))
    else $error("self-test bit read wrong");
  a_test_clock_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_q.st_en |=> oscillator_source_select == bicr_pkg::bicr_osc_t'($past(s_q.osc_fld)))
    else $error("self-test clock source wrong");
  a_func_clock_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
    !s_q.st_en && s_q.osc_fld == 2'h0 |=> oscillator_source_select == bicr_pkg::OSC_50)
    else $error("code 00 must give 50 MHz outside self-test");
  a_wd_disabled_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_q.wd_reg[bicr_pkg::WD_DIS_BIT] [*2] |-> !wd_abort)
    else $error("abort while watchdog disabled");
  a_wd_abort_timing: assert property (@(posedge core_clk) disable iff (!rst_n)
    wd_abort |-> $past(s_q.units) == $past(wd_timeout) - 7'h01 || $past(wd_timeout) == 7'h00)
    else $error("abort at wrong step count");
  a_fwd_own_id: assert property (@(posedge core_clk) disable iff (!rst_n)
    target.valid && target.id == own_id |=> fwd_drop && !fwd_go)
    else $error("own ID access was forwarded");
  a_fwd_filtered: assert property (@(posedge core_clk) disable iff (!rst_n)
    target.valid && !s_q.lbc_reg[bicr_pkg::PASS_ALL_BIT] && target.id != remote_deser_id
      && target.id != remote_target_id |=> !fwd_go)
    else $error("unmatched ID forwarded without pass-all");
endmodule : bicr_ctrl_regs
`default_nettype wire

/* verilog/bicr_glitch_filter.sv */
/*
  One bus input line: three-stage synchroniser and programmable glitch rejection.
  Assumes the raw line is asynchronous to core_clk.
*/
`default_nettype none
module bicr_glitch_filter (
  input  wire logic       core_clk, // Core clock
  input  wire logic       rst_n,    // Synchronous reset
  input  wire logic       line_raw, // Pin level
  input  wire logic [3:0] depth,    // Filter depth, 5 ns steps
  output logic            line_out  // Filtered level
);
  typedef struct packed {
    logic [2:0] sync;
    logic [4:0] cnt;
    logic       out;
  } bicr_filt_state_t;

  bicr_filt_state_t s_q;
  bicr_filt_state_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.sync = {s_q.sync[1:0], line_raw};
    // Only stages 1 and 2 are looked at; stage 0 may be metastable
    if ((s_q.sync[1] != s_q.sync[2]) || (s_q.sync[2] == s_q.out))
      s_d.cnt = 5'h00;
    else if (s_q.cnt >= bicr_pkg::filt_cycles(depth))
    begin
      s_d.out = s_q.sync[2];
      s_d.cnt = 5'h00;
    end
    else
      s_d.cnt = s_q.cnt + 5'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      s_q <= '{sync: 3'h7, cnt: 5'h00, out: 1'b1};
    else
      s_q <= s_d;
  end

  assign line_out = s_q.out;

  a_pulse_rejected: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(s_q.out) |-> $past(s_q.cnt) >= bicr_pkg::filt_cycles($past(depth)))
    else $error("filtered line changed before the depth elapsed");
endmodule : bicr_glitch_filter
`default_nettype wire

/* verilog/bicr_pkg.sv */
/*
  Shared constants and types for the self-test clock, bus-level, watchdog and local bus control register slice.
  Assumes a single 250 MHz core clock and a decoded byte-wide register access port.
*/
`default_nettype none
package bicr_pkg;
  localparam logic [7:0] SELF_TEST_OFF  = 8'h14;
  localparam logic [7:0] LEVEL_OFF      = 8'h15;
  localparam logic [7:0] WATCHDOG_OFF   = 8'h16;
  localparam logic [7:0] LOCAL_BUS_OFF  = 8'h17;
  localparam logic [7:0] SELF_TEST_RST  = 8'h00;
  localparam logic [7:0] LEVEL_RST      = 8'h01;
  localparam logic [7:0] WATCHDOG_RST   = 8'hfe;
  localparam logic [7:0] LOCAL_BUS_RST  = 8'h1e;
  localparam logic [7:0] LEVEL_SET_KEY  = 8'hb5;
  localparam logic [7:0] LEVEL_CLR_KEY  = 8'hb6;
  localparam int         ST_EN_BIT      = 0;
  localparam int         OSC_LSB        = 1;
  localparam int         WD_DIS_BIT     = 0;
  localparam int         WD_TO_LSB      = 1;
  localparam int         PASS_ALL_BIT   = 7;
  localparam int         HOLD_LSB       = 4;
  localparam int         FILT_LSB       = 0;
  localparam int         CLK_PERIOD_PS  = 4000;
  localparam int         WD_STEP_MS     = 2;
  localparam int         HOLD_STEP_NS   = 40;
  localparam int         FILT_STEP_NS   = 5;
  localparam int         WD_UNIT_CYC    = WD_STEP_MS * 1000000000 / CLK_PERIOD_PS;
  localparam int         HOLD_STEP_CYC  = (HOLD_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int         HOLD_MAX_CYC   = 7 * HOLD_STEP_CYC;

  typedef enum logic [1:0] {
    OSC_PIXEL = 2'h0,
    OSC_50    = 2'h1,
    OSC_100   = 2'h2,
    OSC_25    = 2'h3
  } bicr_osc_t;

  typedef enum logic [1:0] {
    WD_IDLE  = 2'h0,
    WD_RUN   = 2'h1,
    WD_ABORT = 2'h3
  } bicr_wd_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bicr_reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] id;
  } bicr_target_t;

  // Least time: filter depth rounds up to whole cycles
  function automatic logic [4:0] filt_cycles(input logic [3:0] depth);
    int ps;
    ps = int'(depth) * FILT_STEP_NS * 1000;
    filt_cycles = 5'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction : filt_cycles
endpackage : bicr_pkg
`default_nettype wire
